// [pkg/qpmux_defines.vh]
// Constants for the quadrature phase pin multiplexer
`ifndef QPMUX_DEFINES_VH
`define QPMUX_DEFINES_VH

// Register offsets (word index on the plain register port)
`define QPMUX_ADDR_W        4
`define QPMUX_REG_FUNC      4'h0
`define QPMUX_REG_DIR       4'h1
`define QPMUX_REG_DATA      4'h2
`define QPMUX_REG_PULLUP    4'h3
`define QPMUX_REG_PINS      4'h4

// Pin function select codes, 2 bits per pin
`define QPMUX_FN_QUAD       2'h0
`define QPMUX_FN_TIMER      2'h1
`define QPMUX_FN_GPIO       2'h2

// Field positions
`define QPMUX_FN_A_LSB      0
`define QPMUX_FN_B_LSB      2
`define QPMUX_BIT_A         4
`define QPMUX_BIT_B         5

// Reset values
`define QPMUX_FUNC_RST      4'h0
`define QPMUX_DIR_RST       8'h00
`define QPMUX_DATA_RST      8'h00
`define QPMUX_PULLUP_RST    8'h30
`define QPMUX_DATA_W        8

`endif

// [hdl/qpmux_pin_slice.v]
// One phase pin: function select and pad drive
`timescale 1ns/10ps
`include "qpmux_defines.vh"

module qpmux_pin_slice (
   input  wire [1:0] funcSel,
   input  wire       gpioDir,
   input  wire       gpioOut,
   input  wire       timerOut,
   input  wire       timerOe,
   input  wire       pinIn,
   output reg        padOut,
   output reg        padOe,
   output reg        quadIn,
   output reg        timerIn,
   output reg        gpioIn
);

   always @* begin
      padOut  = 1'b0;
      padOe   = 1'b0;
      quadIn  = 1'b0;
      timerIn = 1'b0;
      gpioIn  = 1'b0;
      case (funcSel)
         `QPMUX_FN_TIMER: begin
            padOut  = timerOut;
            padOe   = timerOe;
            timerIn = pinIn;
         end
         `QPMUX_FN_GPIO: begin
            padOut = gpioOut;
            padOe  = gpioDir;
            gpioIn = pinIn;
         end
         default: begin
            quadIn = pinIn;
         end
      endcase
   end

endmodule

// [hdl/qpmux_top.v]
// Quadrature phase pin multiplexer with pull-up control
//
// How it works
// - Phase A pin: decoder, timer ch0, gpio 4
// - Phase B pin: decoder, timer ch1, gpio 5
// - GPIO direction set per pin
// - Phase A pin defaults to decoder after reset
// - Phase B pin defaults to decoder after reset
// - Pull-up bit 4 controls phase A pull-up
// - Pull-up bit 5 controls phase B pull-up
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`include "qpmux_defines.vh"

module qpmux_top (
   input  wire                     clk,
   input  wire                     rst_n,
   input  wire [`QPMUX_ADDR_W-1:0] regAddr,
   input  wire [7:0]               regWdata,
   input  wire                     regWr,
   input  wire                     regRd,
   output reg  [7:0]               regRdata,
   input  wire                     quadPhaseAPinIn,
   output reg                      quadPhaseAPinOut,
   output reg                      quadPhaseAPinOe,
   output reg                      quadPhaseAPullupEn,
   input  wire                     quadPhaseBPinIn,
   output reg                      quadPhaseBPinOut,
   output reg                      quadPhaseBPinOe,
   output reg                      quadPhaseBPullupEn,
   input  wire                     timerAChan0Out,
   input  wire                     timerAChan0Oe,
   input  wire                     timerAChan1Out,
   input  wire                     timerAChan1Oe,
   output reg                      quadPhaseA,
   output reg                      quadPhaseB,
   output reg                      timerAChan0In,
   output reg                      timerAChan1In
);

   localparam          DW         = `QPMUX_DATA_W;
   localparam [DW-1:0] DIR_RST    = `QPMUX_DIR_RST;
   localparam [DW-1:0] DATA_RST   = `QPMUX_DATA_RST;
   localparam [DW-1:0] PULLUP_RST = `QPMUX_PULLUP_RST;
   localparam [DW-1:0] ZERO       = {DW{1'b0}};

   reg  [3:0]    funcSel_reg;
   reg  [DW-1:0] portCDir_reg;
   reg  [DW-1:0] portCData_reg;
   reg  [DW-1:0] portCPullupEnable_reg;
   reg  [DW-1:0] rdata_next;

   wire          wrFunc;
   wire          wrDir;
   wire          wrData;
   wire          wrPullup;
   wire [1:0]    selA;
   wire [1:0]    selB;

   wire          aOut;
   wire          aOe;
   wire          aQuad;
   wire          aTimer;
   wire          aGpio;
   wire          bOut;
   wire          bOe;
   wire          bQuad;
   wire          bTimer;
   wire          bGpio;

   // Write hit on one register index
   function hit;
      input                     strobe;
      input [`QPMUX_ADDR_W-1:0] addr;
      input [`QPMUX_ADDR_W-1:0] index;
      begin
         hit = strobe && (addr == index);
      end
   endfunction

   // Function field of pin A or pin B
   function [1:0] fieldOf;
      input [3:0] sel;
      input       pinB;
      begin
         if (pinB) begin
            fieldOf = sel[`QPMUX_FN_B_LSB+1:`QPMUX_FN_B_LSB];
         end else begin
            fieldOf = sel[`QPMUX_FN_A_LSB+1:`QPMUX_FN_A_LSB];
         end
      end
   endfunction

   assign wrFunc   = hit(regWr, regAddr, `QPMUX_REG_FUNC);
   assign wrDir    = hit(regWr, regAddr, `QPMUX_REG_DIR);
   assign wrData   = hit(regWr, regAddr, `QPMUX_REG_DATA);
   assign wrPullup = hit(regWr, regAddr, `QPMUX_REG_PULLUP);
   assign selA     = fieldOf(funcSel_reg, 1'b0);
   assign selB     = fieldOf(funcSel_reg, 1'b1);

   // Function select; decoder on both pins out of reset
   always @(posedge clk) begin
      if (!rst_n) begin
         funcSel_reg <= `QPMUX_FUNC_RST;
      end else if (wrFunc) begin
         funcSel_reg <= regWdata[3:0];
      end
   end

   // Direction, one bit per pin
   always @(posedge clk) begin
      if (!rst_n) begin
         portCDir_reg <= DIR_RST;
      end else if (wrDir) begin
         portCDir_reg <= regWdata;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         portCData_reg <= DATA_RST;
      end else if (wrData) begin
         portCData_reg <= regWdata;
      end
   end

   // Pull-ups come out of reset enabled
   always @(posedge clk) begin
      if (!rst_n) begin
         portCPullupEnable_reg <= PULLUP_RST;
      end else if (wrPullup) begin
         portCPullupEnable_reg <= regWdata;
      end
   end

   qpmux_pin_slice sliceA (
      .funcSel  (selA),
      .gpioDir  (portCDir_reg[`QPMUX_BIT_A]),
      .gpioOut  (portCData_reg[`QPMUX_BIT_A]),
      .timerOut (timerAChan0Out),
      .timerOe  (timerAChan0Oe),
      .pinIn    (quadPhaseAPinIn),
      .padOut   (aOut),
      .padOe    (aOe),
      .quadIn   (aQuad),
      .timerIn  (aTimer),
      .gpioIn   (aGpio)
   );

   qpmux_pin_slice sliceB (
      .funcSel  (selB),
      .gpioDir  (portCDir_reg[`QPMUX_BIT_B]),
      .gpioOut  (portCData_reg[`QPMUX_BIT_B]),
      .timerOut (timerAChan1Out),
      .timerOe  (timerAChan1Oe),
      .pinIn    (quadPhaseBPinIn),
      .padOut   (bOut),
      .padOe    (bOe),
      .quadIn   (bQuad),
      .timerIn  (bTimer),
      .gpioIn   (bGpio)
   );

   // Read mux; pins read back through the pad in GPIO function only, zero otherwise
   always @* begin
      rdata_next = ZERO;
      case (regAddr)
         `QPMUX_REG_FUNC:   rdata_next = {{(DW-4){1'b0}}, funcSel_reg};
         `QPMUX_REG_DIR:    rdata_next = portCDir_reg;
         `QPMUX_REG_DATA:   rdata_next = portCData_reg;
         `QPMUX_REG_PULLUP: rdata_next = portCPullupEnable_reg;
         `QPMUX_REG_PINS: begin
            rdata_next[`QPMUX_BIT_A] = aGpio;
            rdata_next[`QPMUX_BIT_B] = bGpio;
         end
         default: rdata_next = ZERO;
      endcase
   end

   // Read data stands one cycle, zero otherwise
   always @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= ZERO;
      end else begin
         regRdata <= regRd ? rdata_next : ZERO;
      end
   end

   // Pad A drive
   always @(posedge clk) begin
      if (!rst_n) begin
         quadPhaseAPinOut <= DATA_RST[`QPMUX_BIT_A];
         quadPhaseAPinOe  <= DIR_RST[`QPMUX_BIT_A];
      end else begin
         quadPhaseAPinOut <= aOut;
         quadPhaseAPinOe  <= aOe;
      end
   end

   // Pad B drive
   always @(posedge clk) begin
      if (!rst_n) begin
         quadPhaseBPinOut <= DATA_RST[`QPMUX_BIT_B];
         quadPhaseBPinOe  <= DIR_RST[`QPMUX_BIT_B];
      end else begin
         quadPhaseBPinOut <= bOut;
         quadPhaseBPinOe  <= bOe;
      end
   end

   // Pull-up controls
   always @(posedge clk) begin
      if (!rst_n) begin
         quadPhaseAPullupEn <= PULLUP_RST[`QPMUX_BIT_A];
         quadPhaseBPullupEn <= PULLUP_RST[`QPMUX_BIT_B];
      end else begin
         quadPhaseAPullupEn <= portCPullupEnable_reg[`QPMUX_BIT_A];
         quadPhaseBPullupEn <= portCPullupEnable_reg[`QPMUX_BIT_B];
      end
   end

   // Decoder phase inputs
   always @(posedge clk) begin
      if (!rst_n) begin
         quadPhaseA <= ZERO[0];
         quadPhaseB <= ZERO[0];
      end else begin
         quadPhaseA <= aQuad;
         quadPhaseB <= bQuad;
      end
   end

   // Timer capture inputs
   always @(posedge clk) begin
      if (!rst_n) begin
         timerAChan0In <= ZERO[0];
         timerAChan1In <= ZERO[0];
      end else begin
         timerAChan0In <= aTimer;
         timerAChan1In <= bTimer;
      end
   end

endmodule

// [tb/qpmux_chk.sv]
// Port assertions for the phase pin multiplexer
`timescale 1ns/10ps
module qpmux_chk (
   input wire       clk, rst_n, regWr,
   input wire [3:0] regAddr,
   input wire [7:0] regWdata,
   input wire       quadPhaseAPinIn, quadPhaseBPinIn, quadPhaseAPinOe, quadPhaseBPinOe,
   input wire       quadPhaseAPullupEn, quadPhaseBPullupEn,
   input wire       quadPhaseA, quadPhaseB, timerAChan0In, timerAChan1In
);
   logic [3:0] fn;
   logic [1:0] dir;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow of function and direction
   always @(posedge clk)
      if (!rst_n) begin fn <= 4'h0; dir <= 2'h0; end
      else if (regWr && regAddr == 4'h0) fn <= regWdata[3:0];
      else if (regWr && regAddr == 4'h1) dir <= regWdata[5:4];
   quad_a_a: assert property (fn[1:0] != 2'h1 && fn[1:0] != 2'h2 |=>
      quadPhaseA == $past(quadPhaseAPinIn)) else $error("phase A decoder");
   quad_b_a: assert property (!(fn[3:2] inside {2'h1, 2'h2}) |=>
      quadPhaseB == $past(quadPhaseBPinIn)) else $error("phase B decoder");
   tmr_a_a: assert property (fn[1:0] == 2'h1 |=> timerAChan0In == $past(quadPhaseAPinIn)
      && !quadPhaseA) else $error("timer 0 input");
   tmr_b_a: assert property (fn[3:2] == 2'h1 |=> timerAChan1In == $past(quadPhaseBPinIn)
      && !quadPhaseB) else $error("timer 1 input");
   dir_a_a: assert property (fn[1:0] == 2'h2 |=> quadPhaseAPinOe == $past(dir[0]))
      else $error("pin A direction");
   dir_b_a: assert property (fn[3:2] == 2'h2 |=> quadPhaseBPinOe == $past(dir[1]))
      else $error("pin B direction");
   pull_a_a: assert property (regWr && regAddr == 4'h3 |=> ##1
      quadPhaseAPullupEn == $past(regWdata[4], 2)) else $error("pull-up A");
   pull_b_a: assert property (regWr && regAddr == 4'h3 |=> ##1
      quadPhaseBPullupEn == $past(regWdata[5], 2)) else $error("pull-up B");
   rst_out_a: assert property ($rose(rst_n) |-> quadPhaseAPullupEn && quadPhaseBPullupEn
      && !quadPhaseAPinOe && !quadPhaseBPinOe) else $error("reset pin state");
   cover property (fn[1:0] == 2'h2 && dir[0]);
   cover property (fn[3:2] == 2'h1);
   cover property ($rose(rst_n));
endmodule
bind qpmux_top qpmux_chk u_chk (.*);

// [tb/qpmux_enc_model.sv]
// Encoder on the two phase pins, device drive wins
`timescale 1ns/10ps
module qpmux_enc_model (
   input wire  clk, step, quadPhaseAPinOut, quadPhaseAPinOe, quadPhaseBPinOut, quadPhaseBPinOe,
   output wire quadPhaseAPinIn, quadPhaseBPinIn
);
   logic [1:0] cnt = 2'h0;
   always @(posedge clk) if (step) cnt <= cnt + 2'h1;
   assign quadPhaseAPinIn = quadPhaseAPinOe ? quadPhaseAPinOut : cnt[1];
   assign quadPhaseBPinIn = quadPhaseBPinOe ? quadPhaseBPinOut : cnt[1] ^ cnt[0];
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the phase pin multiplexer
`timescale 1ns/10ps
module tb_top;
   logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, step = 0;
   logic timerAChan0Out = 0, timerAChan0Oe = 0, timerAChan1Out = 0, timerAChan1Oe = 0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00, regRdata, g, d, f;
   logic [1:0] p;
   logic [2:0] ra, rb;
   wire quadPhaseAPinIn, quadPhaseAPinOut, quadPhaseAPinOe, quadPhaseAPullupEn, quadPhaseA;
   wire quadPhaseBPinIn, quadPhaseBPinOut, quadPhaseBPinOe, quadPhaseBPullupEn, quadPhaseB;
   wire timerAChan0In, timerAChan1In;
   int errorCnt = 0, nCompared = 0;
   initial forever #4 clk = ~clk;
   qpmux_enc_model ENC (.*);
   qpmux_top DUT (.*);
   task automatic chk(input logic [7:0] got, exp);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      regWr <= 1; regAddr <= a; regWdata <= v; @(posedge clk);
      regWr <= 0; @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      regRd <= 1; regAddr <= a; @(posedge clk);
      regRd <= 0; #1 chk(regRdata, e); @(posedge clk);
   endtask
   // Expected {Oe, Oe and Out} for one pin
   function automatic logic [1:0] padx(input logic [1:0] f, input logic r, o, te, to);
      return f == 2'h2 ? {r, r & o} : f == 2'h1 ? {te, te & to} : 2'h0;
   endfunction
   // Expected {decoder, timer, gpio} view of one pin
   function automatic logic [2:0] route(input logic [1:0] f, input logic pin);
      return {pin & f != 2'h1 & f != 2'h2, pin & f == 2'h1, pin & f == 2'h2};
   endfunction
   task automatic end_sim;
      $display("compared %0d errors %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin #100000; errorCnt++; end_sim; end
   initial begin
      void'($urandom(7));
      repeat (6) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      #1 chk({quadPhaseBPullupEn, quadPhaseAPullupEn, quadPhaseBPinOe, quadPhaseAPinOe}, 8'hc);
      @(posedge clk);
      rd(4'h3, 8'h30);
      rd(4'h0, 8'h00);
      rd(4'hf, 8'h00);
      #1 p = {quadPhaseBPinIn, quadPhaseAPinIn};
      repeat (60) begin
         step <= $urandom;
         @(posedge clk);
         #1 chk({quadPhaseB, quadPhaseA}, p);
         p = {quadPhaseBPinIn, quadPhaseAPinIn};
      end
      step <= 0;
      for (int i = 0; i < 40; i++) begin
         g = $urandom; d = $urandom;
         f = i < 16 ? i : $urandom;
         {timerAChan0Out, timerAChan0Oe, timerAChan1Out, timerAChan1Oe} <= $urandom;
         wr(4'h1, g); wr(4'h2, d); wr(4'h0, f);
         #1 chk({quadPhaseAPinOe, quadPhaseAPinOe & quadPhaseAPinOut},
                padx(f[1:0], g[4], d[4], timerAChan0Oe, timerAChan0Out));
         chk({quadPhaseBPinOe, quadPhaseBPinOe & quadPhaseBPinOut},
             padx(f[3:2], g[5], d[5], timerAChan1Oe, timerAChan1Out));
         @(posedge clk);
         #1 ra = route(f[1:0], quadPhaseAPinIn);
         rb = route(f[3:2], quadPhaseBPinIn);
         chk({quadPhaseB, quadPhaseA}, {rb[2], ra[2]});
         chk({timerAChan1In, timerAChan0In}, {rb[1], ra[1]});
         @(posedge clk);
         rd(4'h4, {2'h0, rb[0], ra[0], 4'h0});
      end
      for (int v = 0; v < 4; v++) begin
         wr(4'h3, 8'(v << 4));
         #1 chk({quadPhaseBPullupEn, quadPhaseAPullupEn}, 8'(v));
         @(posedge clk);
      end
      wr(4'h3, 8'h00); wr(4'h1, 8'h30); wr(4'h0, 8'h0a);
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      #1 chk({quadPhaseBPullupEn, quadPhaseAPullupEn, quadPhaseBPinOe, quadPhaseAPinOe}, 8'hc);
      @(posedge clk);
      end_sim;
   end
endmodule
